// File: shared/pmem_pkg.sv
// Purpose: Constants and carrier types for the packet memory bus master.
// Assumes: Byte-addressed 24-bit packet address, Wishbone word registers.
// Notes: Offsets are byte addresses of 32-bit aligned registers.
package pmem_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int PD_W = 36;
  localparam int PA_W = 16;
  localparam int CNT_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MATCH = 8'h04;
  localparam logic [7:0] OFF_START = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_WDATA = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_PAR_ERR = 1;
  localparam int STAT_DONE = 2;
  // Reset values
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  // Address steps per transfer
  localparam logic [15:0] STEP_WIDE = 16'h0004;
  localparam logic [15:0] STEP_NARROW = 16'h0002;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_RELEASE} bus_state_t;

  // Control register layout, bit 0 is parity_sense
  typedef struct packed {
    logic write_dir;
    logic async_interface_select;
    logic bank_interleave_enable;
    logic addr_on_data_enable;
    logic narrow_16bit_select;
    logic parity_check_enable;
    logic parity_sense;
  } mode_t;

  typedef struct packed {
    bus_state_t st;
    mode_t mode;
    logic [15:0] match;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] count;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic par_err;
    logic done;
    logic req;
    logic cyc_n;
    logic match_flag;
    logic rdy_dly;
    logic rdy_s1;
    logic rdy_s2;
    logic gnt_s1;
    logic gnt_s2;
    logic ack;
    logic [DATA_W-1:0] wb_rdat;
  } core_state_t;
endpackage : pmem_pkg

// File: core/packet_memory_bus_master.sv
// Purpose: Packet memory bus master with request/grant, ready pacing, parity.
// Assumes: Pins are synchronous to core_clk_in except in async mode.
// Notes: Address bus and address-on-data follow addr_half_select_in directly.
`timescale 1ns/1ps

// Operation
// RL1: Top four data lines carry byte parity
// RL2: Parity sense 0 odd, 1 even
// RL3: Writer generates parity; reader checks when enabled
// RL4: Narrow mode uses data 15:0, parity 33:32
// RL5: Address on data during request with half-select
// RL6: Data tri-stated requesting without grant, half low
// RL7: Half-select muxes address halves combinationally
// RL8: Interleave puts bit 2 or 1 on line 0
// RL9: Compare address 13:2 with match register
// RL10: Release and re-request on 16-bit rollover
// RL11: Drop request the cycle after grant seen
// RL12: Arbiter holds grant during transfer, then drops
// RL13: Cycle strobe with request drop; gates address bus
// RL14: No strobes; writer drives data during cycle
// RL15: Delayed ready latches data, advances address
// RL16: After last word release cycle and buses
// RL17: Outside logic drops ready and grant afterwards
// RL18: Preempted by grant loss; resume later
// RL19: Async mode drops request, starts cycle on grant
// RL20: Async ready only when memory finished
// RL21: Async ready synchronized ends single transfer
// RL22: Async grant loss invalidates transfer, retry
// RL23: Async select chooses single or burst accesses
module packet_memory_bus_master (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [pmem_pkg::DATA_W-1:0] wb_dat_in,
  output logic [pmem_pkg::DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [pmem_pkg::PD_W-1:0] packet_data_in,
  output logic [pmem_pkg::PD_W-1:0] packet_data_out,
  output logic packet_data_oe_n_out,
  output logic [pmem_pkg::PA_W-1:0] packet_addr_out,
  output logic packet_addr_oe_n_out,
  output logic mem_bus_request_out,
  input wire logic mem_bus_grant_in,
  input wire logic addr_half_select_in,
  output logic transfer_cycle_active_n_out,
  input wire logic transfer_ready_n_in,
  output logic addr_match_flag_out
);
  import pmem_pkg::*;

  core_state_t q;
  core_state_t d;
  logic [PAR_W-1:0] tx_par;
  logic [PAR_W-1:0] rx_par;
  logic [PAR_W-1:0] par_mask;
  logic [3:0] upper_ok;
  logic match_hit;
  logic eff_grant;
  logic eff_ready;
  logic [15:0] step;
  logic [16:0] low_sum;
  logic [ADDR_W-1:0] next_addr;
  logic wb_hit;
  logic [DATA_W-1:0] wb_merge;
  logic addr_phase;
  logic data_phase;
  logic [DATA_W-1:0] read_word;
  logic [PD_W-1:0] data_word;
  logic [DATA_W-1:0] match_merge;
  logic [DATA_W-1:0] start_merge;

  // Byte lane merge for Wishbone writes
  function automatic logic [DATA_W-1:0] merge_sel(input logic [DATA_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [3:0] sel);
    logic [DATA_W-1:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge_sel

  // Per-byte parity, generated and expected
  genvar gi;
  generate
    for (gi = 0; gi < PAR_W; gi++) begin : g_par
      assign tx_par[gi] = ^q.wdata[gi*8 +: 8] ^ ~q.mode.parity_sense; // [RL1] [RL2] [RL3]
      assign rx_par[gi] = ^packet_data_in[gi*8 +: 8] ^ ~q.mode.parity_sense; // [RL2]
    end
    // Upper match bits compared only where register bit is zero
    for (gi = 0; gi < 4; gi++) begin : g_match
      assign upper_ok[gi] = q.match[12+gi] | ~q.addr[14+gi]; // [RL9]
    end
  endgenerate

  // Address compare, step and rollover detection
  assign match_hit = (q.addr[13:2] == q.match[11:0]) && (&upper_ok); // [RL9]
  assign step = q.mode.narrow_16bit_select ? STEP_NARROW : STEP_WIDE;
  assign low_sum = {1'b0, q.addr[15:0]} + {1'b0, step};
  assign next_addr = {q.addr[23:16] + {7'h00, low_sum[16]}, low_sum[15:0]};
  assign par_mask = q.mode.narrow_16bit_select ? 4'h3 : 4'hf; // [RL4]
  assign read_word = q.mode.narrow_16bit_select ? {16'h0000, packet_data_in[15:0]}
                                                : packet_data_in[31:0];

  // Grant and ready as seen by the sequencer in each mode
  assign eff_grant = q.mode.async_interface_select ? q.gnt_s2 : mem_bus_grant_in; // [RL23]
  assign eff_ready = q.mode.async_interface_select ? (q.rdy_s2 & ~q.cyc_n)
                                                   : q.rdy_dly; // [RL15] [RL21] [RL20]
  assign wb_hit = wb_cyc_in & wb_stb_in & ~q.ack;
  assign wb_merge = merge_sel(32'h0000_0000, wb_dat_in, wb_sel_in);
  // Lane merges of the narrower registers, cut to width where used
  assign match_merge = merge_sel({16'h0000, q.match}, wb_dat_in, wb_sel_in);
  assign start_merge = merge_sel({8'h00, q.start_addr}, wb_dat_in, wb_sel_in);

  // Next state: bus slave, status flags, access sequencer
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.rdy_dly = ~transfer_ready_n_in & ~q.cyc_n; // [RL15]
    d.rdy_s1 = ~transfer_ready_n_in; // [RL21]
    d.rdy_s2 = q.rdy_s1;
    d.gnt_s1 = mem_bus_grant_in; // [RL23]
    d.gnt_s2 = q.gnt_s1;
    d.match_flag = match_hit; // [RL9]
    if (wb_hit) begin
      d.ack = 1'b1;
      d.wb_rdat = 32'h0000_0000;
      case (wb_adr_in)
        OFF_CTRL: begin
          d.wb_rdat = {25'h0, q.mode};
          if (wb_we_in && wb_sel_in[0]) begin
            d.mode = mode_t'(wb_dat_in[6:0]);
          end
        end
        OFF_MATCH: begin
          d.wb_rdat = {16'h0000, q.match};
          if (wb_we_in) begin
            d.match = match_merge[15:0];
          end
        end
        OFF_START: begin
          d.wb_rdat = {8'h00, q.start_addr};
          if (wb_we_in) begin
            d.start_addr = start_merge[23:0];
          end
        end
        OFF_COUNT: begin
          d.wb_rdat = {16'h0000, q.count};
          if (wb_we_in && q.st == ST_IDLE) begin
            d.count = wb_merge[15:0];
            d.addr = q.start_addr;
          end
        end
        OFF_WDATA: begin
          d.wb_rdat = q.wdata;
          if (wb_we_in) begin
            d.wdata = merge_sel(q.wdata, wb_dat_in, wb_sel_in);
          end
        end
        OFF_RDATA: begin
          d.wb_rdat = q.rdata;
        end
        OFF_STATUS: begin
          d.wb_rdat = {29'h0, q.done, q.par_err, q.st != ST_IDLE};
          if (wb_we_in && wb_sel_in[0]) begin
            d.par_err = q.par_err & ~wb_dat_in[STAT_PAR_ERR];
            d.done = q.done & ~wb_dat_in[STAT_DONE];
          end
        end
        default: begin
          d.wb_rdat = 32'h0000_0000;
        end
      endcase
    end
    // Sequencer; flags set below win over a clear above
    case (q.st)
      ST_IDLE: begin
        if (q.count != 16'h0000) begin
          d.req = 1'b1;
          d.st = ST_REQ;
        end
      end
      ST_REQ: begin
        if (eff_grant) begin
          d.req = 1'b0; // [RL11] [RL19]
          d.cyc_n = 1'b0; // [RL13] [RL19]
          d.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (eff_ready) begin
          if (!q.mode.write_dir) begin
            d.rdata = read_word; // [RL15]
            if (q.mode.parity_check_enable &&
                |((rx_par ^ packet_data_in[35:32]) & par_mask)) begin
              d.par_err = 1'b1; // [RL3]
            end
          end
          d.addr = next_addr; // [RL15]
          d.count = q.count - 16'h0001;
          if (q.count == 16'h0001) begin
            d.cyc_n = 1'b1; // [RL16]
            d.done = 1'b1;
            d.st = ST_RELEASE;
          end else if (low_sum[16] || q.mode.async_interface_select || !eff_grant) begin
            d.cyc_n = 1'b1; // [RL10] [RL21] [RL23]
            d.st = ST_RELEASE;
          end
        end else if (!eff_grant) begin
          d.cyc_n = 1'b1; // [RL18] [RL22]
          d.st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!eff_grant) begin
          if (q.count != 16'h0000) begin
            d.req = 1'b1; // [RL10] [RL18] [RL22] [RL12] [RL17]
            d.st = ST_REQ;
          end else begin
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.req = 1'b0;
        d.cyc_n = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.mode <= mode_t'(CTRL_RESET);
      q.match <= MATCH_RESET;
      q.cyc_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Data bus drive: address while requesting, write data during cycle
  assign addr_phase = q.mode.addr_on_data_enable & q.req & ~mem_bus_grant_in &
                      addr_half_select_in; // [RL5] [RL6]
  assign data_phase = q.mode.write_dir & ~q.cyc_n; // [RL14] [RL6]
  assign data_word = q.mode.narrow_16bit_select ?
                     {2'b00, tx_par[1:0], 16'h0000, q.wdata[15:0]} : // [RL4]
                     {tx_par, q.wdata}; // [RL1] [RL3]
  assign packet_data_out = addr_phase ? {4'h0, 8'h00, q.addr} : data_word; // [RL5]
  assign packet_data_oe_n_out = ~(addr_phase | data_phase); // [RL6] [RL16]

  // Address bus halves chosen by half select, no clock involved
  assign packet_addr_out = addr_half_select_in ? q.addr[15:0] : // [RL7]
                           q.mode.bank_interleave_enable ?
                           {q.addr[23:9], q.mode.narrow_16bit_select ? q.addr[1] : q.addr[2]} :
                           q.addr[23:8]; // [RL8] [RL7]
  assign packet_addr_oe_n_out = q.cyc_n; // [RL13] [RL16]

  // Registered outputs
  assign mem_bus_request_out = q.req;
  assign transfer_cycle_active_n_out = q.cyc_n;
  assign addr_match_flag_out = q.match_flag;
  assign wb_ack_out = q.ack;
  assign wb_dat_out = q.wb_rdat;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_req_drop;
    (q.st == ST_REQ && eff_grant) |=> !mem_bus_request_out && q.st == ST_XFER;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after grant"); // [RL11]

  property p_cyc_with_drop;
    $fell(mem_bus_request_out) |-> !transfer_cycle_active_n_out && !packet_addr_oe_n_out;
  endproperty
  a_cyc_with_drop: assert property (p_cyc_with_drop) else $error("cycle not started"); // [RL13]

  property p_upper_half;
    (!addr_half_select_in && !q.mode.bank_interleave_enable) |->
      packet_addr_out[7:0] == q.addr[15:8] && packet_addr_out[15:8] == q.addr[23:16];
  endproperty
  a_upper_half: assert property (p_upper_half) else $error("upper address half wrong"); // [RL7]

  property p_interleave_bit;
    (!addr_half_select_in && q.mode.bank_interleave_enable && !q.mode.narrow_16bit_select)
      |-> packet_addr_out[0] == q.addr[2] && packet_addr_out[1] == q.addr[9];
  endproperty
  a_interleave_bit: assert property (p_interleave_bit) else $error("bank bit wrong"); // [RL8]

  property p_parity_sense;
    (data_phase && !addr_phase) |->
      (^{packet_data_out[32], packet_data_out[7:0]}) == ~q.mode.parity_sense;
  endproperty
  a_parity_sense: assert property (p_parity_sense) else $error("byte parity wrong"); // [RL2]

  property p_narrow_lines;
    (data_phase && !addr_phase && q.mode.narrow_16bit_select) |->
      packet_data_out[31:16] == 16'h0000 && packet_data_out[35:34] == 2'b00;
  endproperty
  a_narrow_lines: assert property (p_narrow_lines) else $error("narrow lines used"); // [RL4]

  property p_addr_on_data;
    (q.mode.addr_on_data_enable && q.req && !mem_bus_grant_in && addr_half_select_in) |->
      !packet_data_oe_n_out && packet_data_out[23:0] == q.addr;
  endproperty
  a_addr_on_data: assert property (p_addr_on_data) else $error("address not on data"); // [RL5]

  property p_req_tristate;
    (q.req && !mem_bus_grant_in && !addr_half_select_in) |-> packet_data_oe_n_out;
  endproperty
  a_req_tristate: assert property (p_req_tristate) else $error("data driven in request"); // [RL6]

  property p_rollover;
    (q.st == ST_XFER && eff_ready && low_sum[16] && q.count > 16'h0001) |=>
      transfer_cycle_active_n_out ##1 (q.st != ST_XFER);
  endproperty
  a_rollover: assert property (p_rollover) else $error("no release at rollover"); // [RL10]

  property p_preempt;
    (q.st == ST_XFER && !q.mode.async_interface_select && !mem_bus_grant_in) |=>
      transfer_cycle_active_n_out && packet_addr_oe_n_out;
  endproperty
  a_preempt: assert property (p_preempt) else $error("preempt not honoured"); // [RL18]

  property p_async_single;
    (q.st == ST_XFER && q.mode.async_interface_select && eff_ready) |=>
      transfer_cycle_active_n_out && q.count == $past(q.count) - 16'h0001;
  endproperty
  a_async_single: assert property (p_async_single) else $error("async cycle not ended"); // [RL21]

  property p_match_flag;
    ((q.addr[13:2] == q.match[11:0]) && ((q.addr[17:14] & ~q.match[15:12]) == 4'h0)) |=>
      addr_match_flag_out;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing"); // [RL9]

  property p_last_word;
    (q.st == ST_XFER && eff_ready && q.count == 16'h0001) |=>
      transfer_cycle_active_n_out && packet_addr_oe_n_out && q.done;
  endproperty
  a_last_word: assert property (p_last_word) else $error("last word not released"); // [RL16]

  property p_lower_half;
    addr_half_select_in |-> packet_addr_out == q.addr[15:0];
  endproperty
  a_lower_half: assert property (p_lower_half) else $error("lower address half wrong"); // [RL7]

  property p_reader_silent;
    (!q.mode.write_dir && !addr_phase) |-> packet_data_oe_n_out;
  endproperty
  a_reader_silent: assert property (p_reader_silent) else $error("reader drove data"); // [RL14]

  property p_idle_released;
    (transfer_cycle_active_n_out && !addr_phase) |-> packet_data_oe_n_out && packet_addr_oe_n_out;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("buses not released"); // [RL16]

  property p_async_start;
    (q.st == ST_REQ && q.mode.async_interface_select && q.gnt_s2) |=>
      !transfer_cycle_active_n_out && !mem_bus_request_out;
  endproperty
  a_async_start: assert property (p_async_start) else $error("async cycle not begun"); // [RL19]

  property p_async_grant_loss;
    (q.st == ST_XFER && q.mode.async_interface_select && !eff_ready && !q.gnt_s2) |=>
      transfer_cycle_active_n_out && q.count == $past(q.count);
  endproperty
  a_async_grant_loss: assert property (p_async_grant_loss) else $error("lost word kept"); // [RL22]

  property p_sync_grant;
    (q.st == ST_REQ && !q.mode.async_interface_select && mem_bus_grant_in) |=>
      !transfer_cycle_active_n_out && !packet_addr_oe_n_out;
  endproperty
  a_sync_grant: assert property (p_sync_grant) else $error("sync cycle not begun"); // [RL13]
endmodule : packet_memory_bus_master

// File: tb/pmem_partner.sv
// Purpose: Far-side model: bus arbiter, ready pacing, one memory word.
// Assumes: Grant one edge after request unless held or preempted.
// Notes: Ready pulses every dly+1 cycles; released read data is inverted.
`timescale 1ns/1ps
module pmem_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic request_in,
  input wire logic cycle_n_in,
  input wire logic [35:0] data_in,
  input wire logic data_oe_n_in,
  input wire logic hold_in,
  input wire logic preempt_in,
  input wire logic [3:0] dly_in,
  input wire logic [35:0] rd_word_in,
  output logic grant_out,
  output logic ready_n_out,
  output logic [35:0] data_out,
  output logic [35:0] wr_word_out,
  output logic [7:0] grants_out,
  output logic [7:0] words_out
);
  logic [3:0] cnt_q;
  logic act_q;
  logic act;
  logic give;
  // Ready and read data only inside a granted, active cycle
  assign act = !cycle_n_in && grant_out;
  assign give = !grant_out && request_in && !hold_in && !preempt_in;
  assign ready_n_out = !(act && cnt_q == dly_in);
  assign data_out = act ? rd_word_in : ~rd_word_in;
  // Arbiter, ready pacing and write capture
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      grant_out <= 1'b0;
      cnt_q <= 4'h0;
      act_q <= 1'b0;
      wr_word_out <= 36'h0;
      grants_out <= 8'h0;
      words_out <= 8'h0;
    end else begin
      act_q <= !cycle_n_in;
      if (give) begin
        grant_out <= 1'b1;
        grants_out <= grants_out + 8'h1;
      end else if (preempt_in || (cycle_n_in && act_q)) begin
        grant_out <= 1'b0;
      end
      cnt_q <= (!act || cnt_q == dly_in) ? 4'h0 : cnt_q + 4'h1;
      if (!ready_n_out) begin
        words_out <= words_out + 8'h1;
        if (!data_oe_n_in) wr_word_out <= data_in;
      end
    end
  end
endmodule : pmem_partner

// File: tb/packet_memory_bus_master_bench.sv
// Purpose: Self-checking bench for the packet memory bus master.
// Assumes: Wishbone classic master, partner model on the memory side.
// Notes: Bus answers and the checks after each run taken at the rising edge, other outputs on the falling edge.
`timescale 1ns/1ps
module packet_memory_bus_master_bench;
  import pmem_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, half = 0, hold = 0, pre = 0;
  logic ack, req, gnt, cyc_n, rdy_n, mflag, doe_n, aoe_n;
  logic [7:0] adr = 8'h00, grants, words, g0, w0;
  logic [31:0] wd = 32'h0, rdat, junk;
  logic [35:0] pdi, pdo, wrw, rdw = 36'h0;
  logic [15:0] pa;
  logic [3:0] dly = 4'h1;
  logic [6:0] modes [3] = '{7'h41, 7'h40, 7'h44};
  int err_count = 0, n_checks = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  packet_memory_bus_master dut (.core_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd),
    .wb_dat_out(rdat), .wb_ack_out(ack), .packet_data_in(pdi), .packet_data_out(pdo),
    .packet_data_oe_n_out(doe_n), .packet_addr_out(pa), .packet_addr_oe_n_out(aoe_n),
    .mem_bus_request_out(req), .mem_bus_grant_in(gnt), .addr_half_select_in(half),
    .transfer_cycle_active_n_out(cyc_n), .transfer_ready_n_in(rdy_n),
    .addr_match_flag_out(mflag));
  pmem_partner mem (.clk_in(clk), .rst_in(rst), .request_in(req), .cycle_n_in(cyc_n),
    .data_in(pdo), .data_oe_n_in(doe_n), .hold_in(hold), .preempt_in(pre), .dly_in(dly),
    .rd_word_in(rdw), .grant_out(gnt), .ready_n_out(rdy_n), .data_out(pdi),
    .wr_word_out(wrw), .grants_out(grants), .words_out(words));
  // Byte parity, sense 1 even, 0 odd
  function automatic logic [3:0] par(input logic [31:0] d, input logic s);
    for (int i = 0; i < 4; i++) par[i] = (^d[8*i+:8]) ^ ~s;
  endfunction : par
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, junk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rc
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0) wb(1'b0, OFF_STATUS, 32'h0, s);
  endtask : wait_idle
  task automatic run(input logic [15:0] n);
    g0 = grants;
    w0 = words;
    wr(OFF_COUNT, {16'h0, n});
    wait_idle();
  endtask : run
  task automatic t_regs();
    rc(OFF_CTRL, 32'h7f, {25'h0, CTRL_RESET});
    rc(OFF_MATCH, 32'hffff, {16'h0, MATCH_RESET});
    wr(OFF_MATCH, 32'h5a5a);
    rc(OFF_MATCH, 32'hffff, 32'h5a5a);
    rc(8'h40, 32'hffffffff, 32'h0);
  endtask : t_regs
  task automatic t_addr();
    hold <= 1'b1;
    wr(OFF_CTRL, 32'h08);
    wr(OFF_START, 32'h123404);
    wr(OFF_COUNT, 32'h1);
    half <= 1'b1;
    repeat (3) @(negedge clk);
    chk(pa, 16'h3404);
    chk({doe_n, pdo[31:0]}, {1'b0, 32'h00123404});
    @(posedge clk) half <= 1'b0;
    @(negedge clk);
    chk({pa, doe_n, req}, {16'h1234, 2'b11});
    wr(OFF_CTRL, 32'h18);
    @(negedge clk) chk(pa, {8'h12, 7'h1a, 1'b1});
    wr(OFF_CTRL, 32'h1c);
    @(negedge clk) chk(pa, {8'h12, 7'h1a, 1'b0});
    @(posedge clk) hold <= 1'b0;
    wait_idle();
  endtask : t_addr
  task automatic t_wr();
    for (int i = 0; i < 3; i++) begin
      wr(OFF_STATUS, 32'h6);
      wr(OFF_CTRL, {25'h0, modes[i]});
      wr(OFF_WDATA, 32'h01030700);
      wr(OFF_START, 32'h100);
      run(16'h3);
      chk(grants - g0, 8'h1);
      chk(words - w0, 8'h3);
      chk(wrw & (modes[i][2] ? 36'h3_0000_ffff : 36'hf_ffff_ffff),
        {par(32'h01030700, modes[i][0]), 32'h01030700} &
        (modes[i][2] ? 36'h3_0000_ffff : 36'hf_ffff_ffff));
      chk({cyc_n, doe_n, aoe_n}, 3'b111);
      rc(OFF_STATUS, 32'h4, 32'h4);
    end
  endtask : t_wr
  task automatic t_rd();
    wr(OFF_CTRL, 32'h02);
    rdw <= {par(32'hdeadbeef, 1'b0), 32'hdeadbeef};
    run(16'h1);
    rc(OFF_RDATA, 32'hffffffff, 32'hdeadbeef);
    rc(OFF_STATUS, 32'h2, 32'h0);
    rdw <= {~par(32'hdeadbeef, 1'b0), 32'hdeadbeef};
    run(16'h1);
    rc(OFF_STATUS, 32'h2, 32'h2);
    wr(OFF_STATUS, 32'h6);
    wr(OFF_CTRL, 32'h00);
    run(16'h1);
    rc(OFF_STATUS, 32'h2, 32'h0);
  endtask : t_rd
  task automatic t_async();
    wr(OFF_CTRL, 32'h20);
    dly <= 4'h6;
    rdw <= {4'h0, 32'h13572468};
    run(16'h2);
    chk(grants - g0, 8'h2);
    rc(OFF_RDATA, 32'hffffffff, 32'h13572468);
    dly <= 4'h1;
  endtask : t_async
  task automatic t_roll();
    wr(OFF_CTRL, 32'h40);
    wr(OFF_START, 32'hfffc);
    run(16'h2);
    chk(grants - g0, 8'h2);
    wr(OFF_MATCH, 32'hf001);
    repeat (2) @(negedge clk) chk(mflag, 1'b1);
    wr(OFF_MATCH, 32'hf002);
    repeat (2) @(negedge clk) chk(mflag, 1'b0);
    wr(OFF_MATCH, 32'h0001);
    repeat (2) @(negedge clk) chk(mflag, 1'b0);
  endtask : t_roll
  task automatic t_pre();
    wr(OFF_START, 32'h200);
    dly <= 4'h3;
    g0 = grants;
    wr(OFF_COUNT, 32'h4);
    repeat (8) @(negedge clk);
    @(posedge clk) pre <= 1'b1;
    repeat (3) @(posedge clk);
    pre <= 1'b0;
    wait_idle();
    chk(grants - g0, 8'h2);
    rc(OFF_COUNT, 32'hffff, 32'h0);
    // Async access robbed of its grant before ready is redone
    wr(OFF_CTRL, 32'h60);
    dly <= 4'h6;
    g0 = grants;
    w0 = words;
    wr(OFF_COUNT, 32'h1);
    wait (cyc_n === 1'b0);
    @(posedge clk) pre <= 1'b1;
    repeat (3) @(posedge clk);
    pre <= 1'b0;
    wait_idle();
    chk({grants - g0, words - w0}, {8'h2, 8'h1});
    rc(OFF_COUNT, 32'hffff, 32'h0);
    dly <= 4'h1;
  endtask : t_pre
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_addr();
    t_wr();
    t_rd();
    t_async();
    t_roll();
    t_pre();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule : packet_memory_bus_master_bench
